// ---- slsq_pkg.sv ----
// package: constants, types and register map of the led switch sequencer
`default_nettype none
package slsq_pkg;
  // ----------------------------------------
  // register map (byte offsets)
  // ----------------------------------------
  localparam logic [11:0] OFS_STEP = 12'h000; // step period in ticks, rw
  localparam logic [11:0] OFS_STAT = 12'h004; // sequencer status, ro
  localparam logic [11:0] OFS_CFG = 12'h008; // captured codes, ro
  localparam logic [11:0] OFS_FLT = 12'h00C; // fault latches, ro
  localparam logic [15:0] STEP_RST = 16'h2710; // 10000 ticks = 10 ms
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_NS = 5; // pclk period
  localparam int TICK_NS = 1000; // oscillator tick, 1 us
  localparam int TICK_CYC = TICK_NS / CLK_NS; // pclk cycles per tick
  // fractions of the step period, q15
  localparam logic [10:0] BLANK_Q = 11'h347; // 0.0256
  localparam logic [10:0] BLANK_FADE_Q = 11'h45A; // 0.034
  localparam logic [10:0] PWM_Q = 11'h1B5; // 1/75
  localparam int Q_SHIFT = 15; // q15 scaling
  localparam int WIDTH_SHIFT = 4; // pulse change of 1/16
  // ----------------------------------------
  // switch and code fields
  // ----------------------------------------
  localparam int SW_N = 6; // bypass switches
  localparam logic [5:0] MASK_SW3 = 6'h07; // switches 1-3
  localparam logic [5:0] MASK_SW4 = 6'h1B; // switches 1,2,4,5
  localparam logic [5:0] MASK_SW5 = 6'h1F; // switches 1-5
  localparam logic [5:0] MASK_SW6 = 6'h3F; // all switches
  localparam int DIR_BIT = 3; // dim direction in first code
  localparam int THR_MSB = 2; // threshold field top
  localparam int CNT_MSB = 1; // switch count field top
  localparam int FADE_LSB = 2; // fade field bottom
  // decoded configuration levels, 4 bits each
  typedef struct packed {
    logic [3:0] thr_dir; // threshold_direction_code
    logic [3:0] chain_pos; // chain_position_code
    logic [3:0] sw_fade; // switch_count_fade_code
  } slsq_cfg_t;
  // comparator outputs from the analog front end
  typedef struct packed {
    logic [5:0] open_det; // drain-source above open threshold
    logic [5:0] short_det; // drain-source below short threshold
    logic [5:0] trace_det; // closed switch under minimum current
    logic therm_warn; // thermal warning
    logic therm_shdn; // thermal shutdown
    logic pump_ready; // charge pump in regulation
  } slsq_cmp_t;
  // sequencer states
  typedef enum logic [2:0] {
    ST_OFF, ST_SAMPLE, ST_PUMP, ST_IDLE, ST_WAIT, ST_RUN, ST_DONE
  } slsq_state_t;
endpackage : slsq_pkg
`default_nettype wire

// ---- slsq_top.sv ----
// sequencer core: start-up, chain handoff, stepping, fade, faults, apb registers
//
// Functional notes
// R1: codes captured once; step period live
// R2: sample codes after supply, then release enable
// R3: initial states from direction; first change later
// R4: one switch per step, then hold
// R5: handoff counts rising edges; position code
// R6: pull handoff low while sequencing, release after
// R7: position zero starts at enable; else waits
// R8: all devices hold end states afterwards
// R9: fade ramps brightness via switch pwm
// R10: pulse width times 1.0625 or 0.9375
// R11: pwm frequency 75 over multiplier times period
// R12: each code is a 4-bit level
// R13: low first-code bits select short threshold
// R14: direction bit picks start state and order
// R15: third code low bits pick active switches
// R16: third code high bits set fade length
// R17: fault flag ors all fault conditions
// R18: enable low or undervoltage clears faults
// R19: open led forces that switch closed
// R20: short checked on open switch only
// R21: short blanked at start and transitions
// R22: transition blank is fraction of period
// R23: enable low: switches open, detection off
// R24: enable high starts the configured sequence
// R25: open trace flagged, blanked, sequence continues
// R26: thermal shutdown closes all, cleared by power
// R27: timing counted in oscillator ticks
// R28: comparator inputs synchronised first
//
// Local design decisions: the APB register port and the register addresses.
`default_nettype none
module slsq_top
  import slsq_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYC // pclk cycles per oscillator tick
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // supply and bias
  input wire logic supply_ok,
  input wire logic bias_ready,
  // decoded codes and comparators
  input wire slsq_cfg_t cfg_in,
  input wire slsq_cmp_t cmp_in,
  // enable pin, open drain
  input wire logic en_in,
  output logic en_out,
  output logic en_oe,
  // chain handoff pin, open drain
  input wire logic sync_in,
  output logic sync_out,
  output logic sync_oe,
  // switch gates, threshold select, flag
  output logic [5:0] sw_closed,
  output logic [2:0] short_detect_threshold,
  output logic fault_flag_n
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  slsq_state_t state_r, state_nxt; // sequencer state
  slsq_cfg_t cfg_r; // captured codes
  slsq_cmp_t cmp_m_r, cmp_s_r; // comparator synchroniser
  logic [15:0] tick_cnt_r; // prescaler
  logic tick; // oscillator tick
  logic [15:0] step_len_r; // step period in ticks
  logic [15:0] step_cnt_r; // ticks into step
  logic step_end; // last tick of step
  logic sync_prev_r, sync_rise; // handoff edge
  logic [3:0] edge_cnt_r; // handoff edges seen
  logic [5:0] act, done_r, pend, pick; // switch masks
  logic dim_up, seq_on, run_on, last_sw;
  logic [1:0] fade_n, fade_left_r; // fade multiplier
  logic [5:0] fade_sw_r; // switch being faded
  logic [31:0] pwm_prod, blank_prod; // period products
  logic [15:0] pwm_per, width_r, pwm_cnt_r; // fade pwm
  logic [16:0] width_up; // grown pulse
  logic pwm_wrap, pwm_on;
  logic [15:0] blank_r, blank_sw; // blanking
  logic blank, det_on;
  logic [5:0] open_flt_r, short_flt_r, trace_flt_r; // fault latches
  logic warn_r, shdn_r, pump_flt_r, flt_clr;
  logic [5:0] sw_nxt, sw_r; // switch gates
  logic flag_r; // registered flag, high = fault
  logic [31:0] rdata_nxt, rdata_r;
  logic hit;

  // ----------------------------------------
  // comparator synchroniser
  // ----------------------------------------
  // second stage is the only reader of the first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_m_r <= '0;
      cmp_s_r <= '0;
    end else begin
      cmp_m_r <= cmp_in; // R28
      cmp_s_r <= cmp_m_r;
    end
  end

  // ----------------------------------------
  // oscillator tick and step timer
  // ----------------------------------------
  assign tick = (tick_cnt_r == 16'(TICK_DIV - 1));
  // prescaler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tick_cnt_r <= '0;
    else if (tick) tick_cnt_r <= '0; // R27
    else tick_cnt_r <= tick_cnt_r + 16'h0001;
  end

  assign run_on = (state_r == ST_RUN) || (state_r == ST_DONE);
  // compare against live length so a shorter period applies at once
  assign step_end = run_on && tick && ({1'b0, step_cnt_r} + 17'h00001 >= {1'b0, step_len_r}); // R1
  // ticks into the current step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) step_cnt_r <= '0;
    else if (!run_on || step_end) step_cnt_r <= '0;
    else if (tick) step_cnt_r <= step_cnt_r + 16'h0001; // R27
  end

  // ----------------------------------------
  // configuration decode
  // ----------------------------------------
  // captured once in the sample state only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cfg_r <= '0;
    else if (state_r == ST_SAMPLE) cfg_r <= cfg_in; // R1 R12
  end
  assign short_detect_threshold = cfg_r.thr_dir[THR_MSB:0]; // R13
  assign dim_up = cfg_r.thr_dir[DIR_BIT]; // R14
  assign fade_n = cfg_r.sw_fade[FADE_LSB+1:FADE_LSB]; // R16
  // active switches by count code
  always_comb begin
    case (cfg_r.sw_fade[CNT_MSB:0]) // R15
      2'h0: act = MASK_SW3;
      2'h1: act = MASK_SW4;
      2'h2: act = MASK_SW5;
      default: act = MASK_SW6;
    endcase
  end

  // ----------------------------------------
  // chain handoff edge counter
  // ----------------------------------------
  assign sync_rise = sync_in && !sync_prev_r; // R5
  // edge history and count while waiting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_prev_r <= 1'b1;
      edge_cnt_r <= '0;
    end else begin
      sync_prev_r <= sync_in;
      if (state_r != ST_WAIT) edge_cnt_r <= '0;
      else if (sync_rise) edge_cnt_r <= edge_cnt_r + 4'h1; // R5
    end
  end

  // ----------------------------------------
  // sequencer state machine
  // ----------------------------------------
  // next active switch: lowest first dimming up, highest first down
  assign pend = act & ~done_r;
  always_comb begin
    pick = '0;
    for (int i = 0; i < SW_N; i++) begin
      if (dim_up) begin
        if (pend[i] && pick == 6'h00) pick[i] = 1'b1; // R14
      end else if (pend[SW_N-1-i] && pick == 6'h00) begin
        pick[SW_N-1-i] = 1'b1; // R14
      end
    end
  end
  assign last_sw = ((pend & ~pick) == 6'h00);

  // start-up, enable and chain flow
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF: state_nxt = ST_SAMPLE; // R2
      ST_SAMPLE: state_nxt = ST_PUMP;
      ST_PUMP: begin
        if (cmp_s_r.pump_ready && bias_ready) state_nxt = ST_IDLE; // R2
      end
      ST_IDLE: begin
        if (en_in) state_nxt = (cfg_r.chain_pos == 4'h0) ? ST_RUN : ST_WAIT; // R7 R24
      end
      ST_WAIT: begin
        if (!en_in) state_nxt = ST_IDLE;
        else if (sync_rise && (edge_cnt_r + 4'h1 == cfg_r.chain_pos)) state_nxt = ST_RUN; // R7
      end
      ST_RUN: begin
        if (!en_in) state_nxt = ST_IDLE;
        else if (step_end && last_sw) state_nxt = ST_DONE; // R4
      end
      ST_DONE: begin
        if (!en_in) state_nxt = ST_IDLE; // R8
      end
      default: state_nxt = ST_OFF;
    endcase
    if (!supply_ok) state_nxt = ST_OFF; // undervoltage restarts all
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state_r <= ST_OFF;
    else state_r <= state_nxt;
  end

  // switches already changed; one per step end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) done_r <= '0;
    else if (!run_on) done_r <= '0; // R3
    else if (state_r == ST_RUN && step_end) done_r <= done_r | pick; // R4
  end

  // open drain pins: enable held low through start-up, handoff while running
  assign en_out = 1'b0;
  assign en_oe = (state_r == ST_OFF) || (state_r == ST_SAMPLE) || (state_r == ST_PUMP); // R2
  assign sync_out = 1'b0;
  assign sync_oe = (state_r == ST_RUN); // R6

  // ----------------------------------------
  // fade pwm
  // ----------------------------------------
  // period = multiplier x step / 75
  assign pwm_prod = 32'(step_len_r) * 32'(fade_n) * 32'(PWM_Q); // R11
  assign pwm_per = (pwm_prod[30:Q_SHIFT] == 16'h0000) ? 16'h0001 : pwm_prod[30:Q_SHIFT];
  assign pwm_wrap = tick && ({1'b0, pwm_cnt_r} + 17'h00001 >= {1'b0, pwm_per});
  assign pwm_on = (pwm_cnt_r < width_r);
  assign width_up = {1'b0, width_r} + {5'h00, width_r[15:WIDTH_SHIFT]} + 17'h00001;

  // fading switch and steps left
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fade_sw_r <= '0;
      fade_left_r <= '0;
    end else if (!run_on) begin
      fade_sw_r <= '0;
      fade_left_r <= '0;
    end else if (step_end) begin
      if (state_r == ST_RUN && pick != 6'h00 && fade_n != 2'h0) begin
        fade_sw_r <= pick; // R9 R16
        fade_left_r <= fade_n;
      end else if (fade_left_r > 2'h1) begin
        fade_left_r <= fade_left_r - 2'h1;
      end else begin
        fade_sw_r <= '0;
        fade_left_r <= '0;
      end
    end
  end

  // pulse width grows or shrinks by 1/16 each pwm period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_cnt_r <= '0;
      width_r <= '0;
    end else if (step_end && state_r == ST_RUN && pick != 6'h00) begin
      pwm_cnt_r <= '0;
      width_r <= dim_up ? 16'h0001 : pwm_per; // R9
    end else if (pwm_wrap) begin
      pwm_cnt_r <= '0;
      if (dim_up) width_r <= (width_up > {1'b0, pwm_per}) ? pwm_per : width_up[15:0]; // R10
      else if (width_r > 16'h0001 + (width_r >> WIDTH_SHIFT))
        width_r <= width_r - (width_r >> WIDTH_SHIFT) - 16'h0001; // R10
      else width_r <= '0;
    end else if (tick) begin
      pwm_cnt_r <= pwm_cnt_r + 16'h0001;
    end
  end

  // ----------------------------------------
  // detection blanking
  // ----------------------------------------
  assign blank_prod = (fade_n == 2'h0) ? 32'(step_len_r) * 32'(BLANK_Q)
                                       : 32'(step_len_r) * 32'(fade_n) * 32'(BLANK_FADE_Q); // R22
  assign blank_sw = blank_prod[30:Q_SHIFT];
  assign blank = (blank_r != 16'h0000);
  // half period at start, transition window at each step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) blank_r <= '0;
    else if (state_nxt == ST_RUN && state_r != ST_RUN) blank_r <= step_len_r >> 1; // R21
    else if (state_r == ST_RUN && step_end) blank_r <= blank_sw; // R21 R22
    else if (tick && blank) blank_r <= blank_r - 16'h0001;
  end

  // ----------------------------------------
  // fault latches
  // ----------------------------------------
  assign flt_clr = !en_in || !supply_ok; // R18
  assign det_on = run_on && en_in; // R23
  // led faults; detection off while enable is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_flt_r <= '0;
      short_flt_r <= '0;
      trace_flt_r <= '0;
    end else if (flt_clr) begin
      open_flt_r <= '0;
      short_flt_r <= '0;
      trace_flt_r <= '0;
    end else if (det_on) begin
      open_flt_r <= open_flt_r | (cmp_s_r.open_det & ~sw_r & act); // R19
      if (!blank) begin
        short_flt_r <= short_flt_r | (cmp_s_r.short_det & ~sw_r & act); // R20
        trace_flt_r <= trace_flt_r | (cmp_s_r.trace_det & sw_r & act); // R25
      end
    end
  end

  // warning and pump faults clear with enable; shutdown only by power
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_r <= 1'b0;
      pump_flt_r <= 1'b0;
      shdn_r <= 1'b0;
    end else begin
      warn_r <= !flt_clr && (warn_r || cmp_s_r.therm_warn);
      pump_flt_r <= !flt_clr && (pump_flt_r || (!en_oe && !cmp_s_r.pump_ready)); // R17
      shdn_r <= supply_ok && (shdn_r || cmp_s_r.therm_shdn); // R26
    end
  end

  // flag from any latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) flag_r <= 1'b0;
    else flag_r <= (|open_flt_r) || (|short_flt_r) || (|trace_flt_r)
                   || warn_r || pump_flt_r || shdn_r; // R17
  end
  assign fault_flag_n = !flag_r;

  // ----------------------------------------
  // switch gates
  // ----------------------------------------
  assign seq_on = en_in && (state_r == ST_WAIT || run_on);
  for (genvar g = 0; g < SW_N; g++) begin : g_sw
    // priority: shutdown, enable, unused or open, fade, step state
    always_comb begin
      if (shdn_r) sw_nxt[g] = 1'b1; // R26
      else if (!seq_on) sw_nxt[g] = 1'b0; // R23
      else if (!act[g] || open_flt_r[g]) sw_nxt[g] = 1'b1; // R15 R19
      else if (fade_sw_r[g]) sw_nxt[g] = !pwm_on; // R9
      else sw_nxt[g] = dim_up ^ done_r[g]; // R3 R14
    end
  end
  // registered gate drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sw_r <= '0;
    else sw_r <= sw_nxt;
  end
  assign sw_closed = sw_r;

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  assign pready = 1'b1;
  assign hit = (paddr == OFS_STEP) || (paddr == OFS_STAT) || (paddr == OFS_CFG) || (paddr == OFS_FLT);
  assign pslverr = psel && penable && !hit;
  // read mux
  always_comb begin
    case (paddr)
      OFS_STEP: rdata_nxt = {16'h0000, step_len_r};
      OFS_STAT: rdata_nxt = {16'h0000, edge_cnt_r, done_r, flag_r, sync_oe, dim_up, state_r};
      OFS_CFG: rdata_nxt = {20'h00000, cfg_r};
      OFS_FLT: rdata_nxt = {5'h00, pump_flt_r, shdn_r, warn_r, 2'h0, trace_flt_r,
                            2'h0, short_flt_r, 2'h0, open_flt_r};
      default: rdata_nxt = 32'h00000000;
    endcase
  end
  // read data caught in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rdata_r <= '0;
    else if (psel && !penable && !pwrite) rdata_r <= rdata_nxt;
  end
  assign prdata = rdata_r;
  // step period register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) step_len_r <= STEP_RST;
    else if (psel && penable && pwrite && paddr == OFS_STEP) step_len_r <= pwdata[15:0]; // R1
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_en_startup: assert property ( // R2
    (state_r == ST_PUMP && !(cmp_s_r.pump_ready && bias_ready)) |=> en_oe && !en_out)
    else $error("enable released before pump and bias ready");
  chk_cfg_once: assert property ( // R1
    (state_r != ST_SAMPLE) |=> $stable(cfg_r))
    else $error("codes changed outside sampling");
  chk_en_low_open: assert property ( // R23
    (!en_in && !shdn_r) ##1 !shdn_r |-> sw_r == 6'h00)
    else $error("switch closed while enable low");
  chk_unused_closed: assert property ( // R15
    (state_r == ST_RUN && en_in) |=> ((sw_r & ~$past(act)) == ~$past(act)))
    else $error("unused switch not closed");
  chk_shdn_close: assert property ( // R26
    shdn_r |=> sw_r == 6'h3F && !fault_flag_n)
    else $error("shutdown did not close all switches");
  chk_sync_release: assert property ( // R6
    (state_r == ST_RUN && state_nxt == ST_DONE) |=> !sync_oe ##1 !sync_oe)
    else $error("handoff line not released at end");
  chk_wait_edges: assert property ( // R7
    (state_r == ST_WAIT) |-> edge_cnt_r < cfg_r.chain_pos)
    else $error("waited past chain position");
  chk_short_blank: assert property ( // R21
    (blank && state_r == ST_RUN) |=> (short_flt_r & ~$past(short_flt_r)) == 6'h00)
    else $error("short flagged during blanking");
  chk_open_flag: assert property ( // R19
    (|open_flt_r && !flt_clr) ##1 en_in
      |-> !fault_flag_n ##1 (sw_r & $past(open_flt_r, 2)) == $past(open_flt_r, 2))
    else $error("open fault did not flag or close switch");
  chk_fault_clear: assert property ( // R18
    (!en_in) |=> open_flt_r == 6'h00 && short_flt_r == 6'h00 && !warn_r)
    else $error("faults not cleared by enable low");
  cov_chain_start: cover property (state_r == ST_WAIT ##1 state_r == ST_RUN);
  cov_done: cover property (state_r == ST_RUN ##1 state_r == ST_DONE);
  cov_fade: cover property (fade_sw_r != 6'h00 && pwm_wrap);
  cov_short: cover property (short_flt_r != 6'h00);
endmodule : slsq_top
`default_nettype wire

// ---- slsq_partner.sv ----
// far side model: pulled-up enable and handoff lines plus an upstream chained device
`default_nettype none
module slsq_partner (
  // clock
  input wire logic pclk,
  // open-drain pull-downs
  input wire logic en_oe,
  input wire logic sync_oe,
  input wire logic host_en_low,
  // resolved line levels
  output logic en_in,
  output logic sync_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic up_low_r; // upstream device pulling handoff low
  initial up_low_r = 1'b0;
  // pull-ups hold both lines high unless a party pulls low
  assign en_in = !(en_oe || host_en_low);
  assign sync_in = !(sync_oe || up_low_r);
  // -----------------------------------------
  // upstream device: each of its sequences pulls low, release gives the rising edge
  // -----------------------------------------
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge pclk);
      up_low_r <= 1'b1;
      repeat (4) @(posedge pclk);
      up_low_r <= 1'b0;
      repeat (4) @(posedge pclk);
    end
  endtask : pulses
endmodule : slsq_partner
`default_nettype wire

// ---- tb_top.sv ----
// testbench: power-up, apb registers, stepping, chaining and faults of the sequencer
`default_nettype none
module tb_top
  import slsq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, supply_ok, bias_ready;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  slsq_cfg_t cfg_in;
  slsq_cmp_t cmp_in;
  logic en_in, en_out, en_oe, sync_in, sync_out, sync_oe, en_hold;
  logic [5:0] sw_closed, e6;
  logic [2:0] short_detect_threshold;
  logic fault_flag_n;
  logic [32:0] exp_q[$]; // expected {pslverr, prdata} of pending reads
  int num_errors = 0, total_checks = 0, cyc = 0;
  localparam logic [5:0] MASKS [4] = '{MASK_SW3, MASK_SW4, MASK_SW5, MASK_SW6};
  // short tick so steps last a few dozen cycles
  slsq_top #(.TICK_DIV(2)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .supply_ok, .bias_ready, .cfg_in, .cmp_in, .en_in, .en_out, .en_oe, .sync_in,
    .sync_out, .sync_oe, .sw_closed, .short_detect_threshold, .fault_flag_n);
  slsq_partner P (.pclk, .en_oe, .sync_oe, .host_en_low(en_hold), .en_in, .sync_in);
  // -----------------------------------------
  // clock, timeout, read monitor
  // -----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite) check({pslverr, prdata}, exp_q.pop_front());
  // -----------------------------------------
  // tasks
  // -----------------------------------------
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  // returns on the edge: stimulus lands by nba, outputs read hold their pre-edge values
  task automatic w8(input int n);
    repeat (n) @(posedge pclk);
  endtask : w8
  // one apb transfer; for a read d is the expected {pslverr, prdata}
  task automatic apb(input logic w, input logic [11:0] a, input logic [32:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d[31:0];
    if (!w) exp_q.push_back(d);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // supply cycle with new codes, then wait for enable release
  task automatic pwr(input slsq_cfg_t c);
    en_hold <= 1'b1;
    supply_ok <= 1'b0;
    bias_ready <= 1'b0;
    cfg_in <= c;
    w8(3);
    supply_ok <= 1'b1;
    // bias late: enable must stay pulled low until it comes
    w8(6);
    check({en_out, sync_out, en_oe}, 3'b001);
    bias_ready <= 1'b1;
    for (int i = 0; i < 60 && en_oe !== 1'b0; i++) w8(1);
    check({en_out, sync_out, en_oe}, 3'b000);
    apb(1'b0, OFS_CFG, {21'h0, c});
    apb(1'b1, OFS_STEP, 33'h10);
    cfg_in <= ~c;
    apb(1'b0, OFS_CFG, {21'h0, c});
    check(short_detect_threshold, c.thr_dir[2:0]);
  endtask : pwr
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  // -----------------------------------------
  // main sequence
  // -----------------------------------------
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    supply_ok = 1'b0;
    bias_ready = 1'b1;
    cfg_in = '0;
    cmp_in = '0;
    cmp_in.pump_ready = 1'b1;
    en_hold = 1'b1;
    void'($urandom(32918));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_STEP, {17'h0, STEP_RST});
    apb(1'b0, 12'h010, 33'h100000000);
    $display("test registers done");
    // dim down start states for every switch-count code
    for (int c = 0; c < 4; c++) begin
      pwr({1'b0, 3'($urandom), 4'h0, 2'b00, 2'(c)});
      en_hold <= 1'b0;
      w8(8);
      check(sw_closed, MASKS[c] ^ 6'h3F);
      check(sync_oe, 1'b1);
      en_hold <= 1'b1;
      w8(4);
      check(sw_closed, 6'h00);
    end
    $display("test switch counts done");
    // dim up, three switches, stepping then hold, then shutdown
    // fade of one step; at this short period the pwm floors to full on
    pwr({1'b1, 3'($urandom), 8'h04});
    en_hold <= 1'b0;
    w8(16);
    check(sw_closed, 6'h3F);
    for (int s = 1; s <= 3; s++) begin
      w8(32);
      e6 = 6'(6'h3F << s);
      check(sw_closed, e6);
    end
    check(sync_oe, 1'b0);
    w8(100);
    check(sw_closed, 6'h38);
    cmp_in.therm_shdn <= 1'b1;
    w8(8);
    check({fault_flag_n, sw_closed}, 7'h3F);
    en_hold <= 1'b1;
    w8(6);
    check(fault_flag_n, 1'b0);
    cmp_in.therm_shdn <= 1'b0;
    $display("test dim up done");
    // dim down, six switches, chain position 2, open led fault
    pwr({1'b0, 3'($urandom), 4'h2, 4'h3});
    check(fault_flag_n, 1'b1);
    en_hold <= 1'b0;
    w8(40);
    check({sync_oe, sw_closed}, 7'h00);
    P.pulses(2);
    w8(16);
    check({sync_oe, sw_closed}, 7'h40);
    w8(32);
    check(sw_closed, 6'h20);
    // open on switch 1, short on open switch 2 and closed switch 6, thermal warning
    cmp_in <= {6'h01, 6'h22, 6'h00, 3'b101};
    w8(8);
    check({fault_flag_n, sw_closed[0]}, 2'b01);
    apb(1'b0, OFS_FLT, {1'b0, 32'h01000201});
    en_hold <= 1'b1;
    cmp_in <= {18'h00000, 3'b001};
    w8(4);
    check({fault_flag_n, sw_closed}, 7'h40);
    $display("test chain done");
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
